// ---- verilog/sdr_cfg.svh ----
// Purpose: Offsets, field positions, reset values and codes of the
//          delta-sigma result and control block.
// Assumes: Byte-wide registers reached through the I2C slave only.
// Notes:   Definitions only.
`ifndef SDR_CFG_SVH
`define SDR_CFG_SVH

// Register offsets
`define SDR_OFS_CTRL0 8'h01
`define SDR_OFS_CTRL1 8'h02
`define SDR_OFS_RES_LO 8'h04
`define SDR_OFS_RES_MID 8'h05
`define SDR_OFS_RES_HI 8'h06
`define SDR_OFS_DAC_LO 8'h07
`define SDR_OFS_DAC_HI 8'h08
`define SDR_OFS_CLKSEL 8'h09

// Control register 0 fields
`define SDR_C0_OFF 7
`define SDR_C0_SLP 6
`define SDR_C0_RST 5
`define SDR_C0_REFERENCE_SOURCE_SELECT 4
`define SDR_C0_OSR_MSB 3
`define SDR_C0_OSR_LSB 0
`define SDR_C0_RESET 8'hE0

// Control register 1 fields
`define SDR_C1_FILTER_DIVIDE_RATIO_FIELD_MSB 7
`define SDR_C1_FILTER_DIVIDE_RATIO_FIELD_LSB 5
`define SDR_C1_VRBUFN 4
`define SDR_C1_VRBUFP 3
`define SDR_C1_HOLD 2
`define SDR_C1_EOC 1
`define SDR_C1_RESET 8'h00

// Clock select
`define SDR_CLKSEL_W 5
`define SDR_CLKSEL_RESET 5'h00

// Result codes
`define SDR_CODE_MAX 24'h7FFFFF
`define SDR_CODE_MIN 24'h800000

// Fixed 7-bit slave address, 0xD0 with the direction bit
`define SDR_I2C_ADDR 7'h68

`endif

// ---- verilog/sdr_pkg.sv ----
// Purpose: Types shared by the result/control block and its I2C slave.
// Assumes: Constants live in sdr_cfg.svh.
// Notes:   One-hot state codes.
package sdr_pkg;

    typedef enum logic [3:0] {
        SDR_MODE_PD = 4'h1,
        SDR_MODE_SLP = 4'h2,
        SDR_MODE_RST = 4'h4,
        SDR_MODE_RUN = 4'h8
    } sdr_mode_t;

    typedef enum logic [5:0] {
        SDR_SL_IDLE = 6'h01,
        SDR_SL_ADDR = 6'h02,
        SDR_SL_ACK = 6'h04,
        SDR_SL_RX = 6'h08,
        SDR_SL_TX = 6'h10,
        SDR_SL_MACK = 6'h20
    } sdr_i2c_st_t;

    typedef struct packed {
        logic stb;
        logic [7:0] addr;
        logic [7:0] data;
    } sdr_wr_t;

    typedef struct packed {
        logic bandgap_en;
        logic pga_en;
        logic mod_en;
        logic sinc_en;
        logic sinc_rst;
    } sdr_anlg_t;

    typedef struct packed {
        logic [3:0] osr_sel;
        logic [2:0] filter_divide_ratio_field_sel;
        logic [4:0] clk_div_sel;
        logic ref_sel;
        logic vrbuf_n;
        logic vrbuf_p;
    } sdr_conv_set_t;

endpackage : sdr_pkg

// ---- verilog/sdr_i2c_slave.sv ----
// Purpose: Byte-level I2C slave with register pointer, read and write.
// Assumes: Pins already synchronous to core_clk.
// Notes:   Drives only the data line; clock line is input only.
`timescale 1ns/100ps
`default_nettype none
`include "sdr_cfg.svh"
module sdr_i2c_slave (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe,
    // Register access
    output sdr_pkg::sdr_wr_t wr,
    output logic [7:0] rd_ptr,
    input wire logic [7:0] rd_data
);
    import sdr_pkg::*;

    sdr_i2c_st_t st_q, st_d;
    logic scl_q, sda_q, scl_p_q, sda_p_q;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic rw_q, rw_d, first_q, first_d, ack_q, ack_d, oe_q, oe_d;
    sdr_wr_t wr_q, wr_d;
    logic start, stop, rise, fall;

    // Bus conditions from the master
    assign start = scl_q & scl_p_q & sda_p_q & ~sda_q;
    assign stop = scl_q & scl_p_q & ~sda_p_q & sda_q;
    assign rise = scl_q & ~scl_p_q;
    assign fall = ~scl_q & scl_p_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        first_d = first_q;
        ack_d = ack_q;
        oe_d = oe_q;
        wr_d = '0;
        if (start) begin
            st_d = SDR_SL_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (stop) begin
            st_d = SDR_SL_IDLE;
            oe_d = 1'b0;
        end else begin
            unique case (st_q)
                SDR_SL_IDLE: begin
                    oe_d = 1'b0;
                end
                SDR_SL_ADDR, SDR_SL_RX: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], sda_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == 4'h8) begin
                        if (st_q == SDR_SL_ADDR) begin
                            if (sh_q[7:1] == `SDR_I2C_ADDR) begin
                                oe_d = 1'b1;
                                rw_d = sh_q[0];
                                first_d = 1'b1;
                                st_d = SDR_SL_ACK;
                            end else begin
                                st_d = SDR_SL_IDLE;
                            end
                        end else begin
                            oe_d = 1'b1;
                            st_d = SDR_SL_ACK;
                            first_d = 1'b0;
                            if (first_q) begin
                                ptr_d = sh_q;
                            end else begin
                                wr_d.stb = 1'b1;
                                wr_d.addr = ptr_q;
                                wr_d.data = sh_q;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                SDR_SL_ACK: begin
                    if (fall) begin
                        cnt_d = 4'h0;
                        if (rw_q) begin
                            sh_d = rd_data;
                            oe_d = ~rd_data[7];
                            st_d = SDR_SL_TX;
                        end else begin
                            oe_d = 1'b0;
                            st_d = SDR_SL_RX;
                        end
                    end
                end
                SDR_SL_TX: begin
                    if (rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall) begin
                        if (cnt_q == 4'h8) begin
                            oe_d = 1'b0;
                            ptr_d = ptr_q + 8'h01;
                            st_d = SDR_SL_MACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = ~sh_q[6];
                        end
                    end
                end
                SDR_SL_MACK: begin
                    if (rise) begin
                        ack_d = ~sda_q;
                    end else if (fall) begin
                        cnt_d = 4'h0;
                        if (ack_q) begin
                            sh_d = rd_data;
                            oe_d = ~rd_data[7];
                            st_d = SDR_SL_TX;
                        end else begin
                            st_d = SDR_SL_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= SDR_SL_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            ack_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= '0;
        end else begin
            st_q <= st_d;
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            first_q <= first_d;
            ack_q <= ack_d;
            oe_q <= oe_d;
            wr_q <= wr_d;
        end
    end

    // Data line only; the clock line is never driven
    assign sda_oe = oe_q;
    assign wr = wr_q;
    assign rd_ptr = ptr_q;

endmodule : sdr_i2c_slave
`default_nettype wire

// ---- verilog/sdr_adc_ctrl.sv ----
// Purpose: Control, result and DAC register logic of a 24-bit
//          delta-sigma converter, reached over an I2C slave.
// Assumes: Raw filter samples arrive as signed words with a valid strobe.
// Notes:   Result registers, DAC pair and controls live here.
`timescale 1ns/100ps
`default_nettype none
`include "sdr_cfg.svh"
module sdr_adc_ctrl #(
    parameter int RAW_W = 28
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Filter samples
    input wire logic [RAW_W-1:0] sample_in,
    input wire logic sample_valid,
    // Converter controls
    output sdr_pkg::sdr_anlg_t anlg_en,
    output sdr_pkg::sdr_conv_set_t conv_set,
    output sdr_pkg::sdr_mode_t conv_mode,
    output logic conv_done,
    // DAC value
    output logic [15:0] dac_value
);
    import sdr_pkg::*;

    // Slave link
    sdr_wr_t wr;
    logic [7:0] rd_ptr;
    logic [7:0] rd_data;
    logic sda_oe_i;

    // Control state
    logic [7:0] ctrl0_q, ctrl0_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [`SDR_CLKSEL_W-1:0] clksel_q, clksel_d;
    logic eoc_q, eoc_d;

    // Result state
    logic [23:0] result_q, result_d;
    logic take_sample;

    // DAC state
    logic [7:0] dal_shadow_q, dal_shadow_d;
    logic [7:0] dal_q, dal_d;
    logic [7:0] dah_q, dah_d;

    // Converter outputs
    sdr_mode_t mode_q, mode_d;
    sdr_anlg_t anlg_q, anlg_d;
    sdr_conv_set_t set_q, set_d;
    logic sda_oe_q;

    sdr_i2c_slave u_slave (
        .core_clk(core_clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe(sda_oe_i),
        .wr(wr),
        .rd_ptr(rd_ptr),
        .rd_data(rd_data)
    );

    // Clamp a raw filter word to the 24-bit code range
    function automatic logic [23:0] saturate(input logic [RAW_W-1:0] raw);
        logic over;
        over = (raw[RAW_W-1:23] != {(RAW_W - 23){1'b0}}) &&
               (raw[RAW_W-1:23] != {(RAW_W - 23){1'b1}});
        if (!over) begin
            saturate = raw[23:0];
        end else if (raw[RAW_W-1]) begin
            saturate = `SDR_CODE_MIN;
        end else begin
            saturate = `SDR_CODE_MAX;
        end
    endfunction : saturate

    // Register writes from the bus
    always_comb begin
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        clksel_d = clksel_q;
        if (wr.stb) begin
            unique case (wr.addr)
                `SDR_OFS_CTRL0: begin
                    ctrl0_d = wr.data;
                end
                `SDR_OFS_CTRL1: begin
                    ctrl1_d = wr.data;
                end
                `SDR_OFS_CLKSEL: begin
                    clksel_d = wr.data[`SDR_CLKSEL_W-1:0];
                end
                default: begin
                    ctrl0_d = ctrl0_q;
                end
            endcase
        end
        ctrl1_d[`SDR_C1_EOC] = 1'b0;
        ctrl1_d[0] = 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl0_q <= `SDR_C0_RESET;
            ctrl1_q <= `SDR_C1_RESET;
            clksel_q <= `SDR_CLKSEL_RESET;
        end else begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            clksel_q <= clksel_d;
        end
    end

    // DAC pair: low byte waits in the shadow until the high byte lands
    always_comb begin
        dal_shadow_d = dal_shadow_q;
        dal_d = dal_q;
        dah_d = dah_q;
        if (wr.stb && wr.addr == `SDR_OFS_DAC_LO) begin
            dal_shadow_d = wr.data;
        end
        if (wr.stb && wr.addr == `SDR_OFS_DAC_HI) begin
            dah_d = wr.data;
            dal_d = dal_shadow_q;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dal_shadow_q <= 8'h00;
            dal_q <= 8'h00;
            dah_q <= 8'h00;
        end else begin
            dal_shadow_q <= dal_shadow_d;
            dal_q <= dal_d;
            dah_q <= dah_d;
        end
    end

    // Samples count only in run mode and while not held
    assign take_sample = sample_valid && (mode_q == SDR_MODE_RUN) &&
                         !ctrl1_q[`SDR_C1_HOLD];

    // Result capture: all three bytes from one sample
    always_comb begin
        result_d = result_q;
        if (take_sample) begin
            result_d = saturate(sample_in);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_q <= 24'h000000;
        end else begin
            result_q <= result_d;
        end
    end

    // Completion flag: a sample in the clearing cycle wins
    always_comb begin
        eoc_d = eoc_q;
        if (wr.stb && wr.addr == `SDR_OFS_CTRL1 &&
            !wr.data[`SDR_C1_EOC]) begin
            eoc_d = 1'b0;
        end
        if (take_sample) begin
            eoc_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eoc_q <= 1'b0;
        end else begin
            eoc_q <= eoc_d;
        end
    end

    // Operating mode from power-down, sleep and reset bits
    always_comb begin
        if (ctrl0_q[`SDR_C0_OFF]) begin
            mode_d = SDR_MODE_PD;
        end else if (ctrl0_q[`SDR_C0_SLP]) begin
            mode_d = SDR_MODE_SLP;
        end else if (ctrl0_q[`SDR_C0_RST]) begin
            mode_d = SDR_MODE_RST;
        end else begin
            mode_d = SDR_MODE_RUN;
        end
        anlg_d = '0;
        unique case (mode_d)
            SDR_MODE_PD: begin
                anlg_d = '0;
            end
            SDR_MODE_SLP: begin
                anlg_d.bandgap_en = 1'b1;
                anlg_d.pga_en = 1'b1;
                anlg_d.sinc_en = 1'b1;
            end
            SDR_MODE_RST: begin
                anlg_d.bandgap_en = 1'b1;
                anlg_d.pga_en = 1'b1;
                anlg_d.mod_en = 1'b1;
                anlg_d.sinc_en = 1'b1;
                anlg_d.sinc_rst = 1'b1;
            end
            SDR_MODE_RUN: begin
                anlg_d.bandgap_en = 1'b1;
                anlg_d.pga_en = 1'b1;
                anlg_d.mod_en = 1'b1;
                anlg_d.sinc_en = 1'b1;
            end
        endcase
    end

    // Mode and analog enables move together
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_q <= SDR_MODE_PD;
            anlg_q <= '0;
        end else begin
            mode_q <= mode_d;
            anlg_q <= anlg_d;
        end
    end

    // Converter settings; reference buffers forced off in power down
    always_comb begin
        set_d.osr_sel = ctrl0_q[`SDR_C0_OSR_MSB:`SDR_C0_OSR_LSB];
        set_d.filter_divide_ratio_field_sel = ctrl1_q[`SDR_C1_FILTER_DIVIDE_RATIO_FIELD_MSB:`SDR_C1_FILTER_DIVIDE_RATIO_FIELD_LSB];
        set_d.clk_div_sel = clksel_q;
        set_d.ref_sel = ctrl0_q[`SDR_C0_REFERENCE_SOURCE_SELECT];
        set_d.vrbuf_n = ctrl1_q[`SDR_C1_VRBUFN] & ~ctrl0_q[`SDR_C0_OFF];
        set_d.vrbuf_p = ctrl1_q[`SDR_C1_VRBUFP] & ~ctrl0_q[`SDR_C0_OFF];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            set_q <= '0;
        end else begin
            set_q <= set_d;
        end
    end

    // Data line enable, one flop after the slave
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sda_oe_q <= 1'b0;
        end else begin
            sda_oe_q <= sda_oe_i;
        end
    end

    // Register read data for slave transmit
    always_comb begin
        unique case (rd_ptr)
            `SDR_OFS_CTRL0: begin
                rd_data = ctrl0_q;
            end
            `SDR_OFS_CTRL1: begin
                rd_data = {ctrl1_q[7:2], eoc_q, 1'b0};
            end
            `SDR_OFS_RES_LO: begin
                rd_data = result_q[7:0];
            end
            `SDR_OFS_RES_MID: begin
                rd_data = result_q[15:8];
            end
            `SDR_OFS_RES_HI: begin
                rd_data = result_q[23:16];
            end
            `SDR_OFS_DAC_LO: begin
                rd_data = dal_q;
            end
            `SDR_OFS_DAC_HI: begin
                rd_data = dah_q;
            end
            `SDR_OFS_CLKSEL: begin
                rd_data = {{(8 - `SDR_CLKSEL_W){1'b0}}, clksel_q};
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

    // Outputs
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;
    assign anlg_en = anlg_q;
    assign conv_set = set_q;
    assign conv_mode = mode_q;
    assign conv_done = eoc_q;
    assign dac_value = {dah_q, dal_q};

endmodule : sdr_adc_ctrl
`default_nettype wire

// ---- testbench/sdr_adc_ctrl_sva.sv ----
// Purpose: Port checks on the result/control block.
// Assumes: One clock; reset asynchronous, active high.
// Notes:   Bound to every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module sdr_adc_ctrl_sva #(
    parameter int RAW_W = 28
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // I2C pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Filter samples
    input wire logic [RAW_W-1:0] sample_in,
    input wire logic sample_valid,
    // Converter controls
    input wire sdr_pkg::sdr_anlg_t anlg_en,
    input wire sdr_pkg::sdr_conv_set_t conv_set,
    input wire sdr_pkg::sdr_mode_t conv_mode,
    input wire logic conv_done,
    input wire logic [15:0] dac_value
);
    import sdr_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Mode settled for three edges
    sequence s_pd; (conv_mode == SDR_MODE_PD) [*3]; endsequence
    sequence s_slp; (conv_mode == SDR_MODE_SLP) [*3]; endsequence
    sequence s_rst; (conv_mode == SDR_MODE_RST) [*3]; endsequence
    sequence s_run; (conv_mode == SDR_MODE_RUN) [*3]; endsequence
    sequence s_take; sample_valid && conv_mode == SDR_MODE_RUN; endsequence
    a_pd_analog_off: assert property (s_pd |-> anlg_en == '0)
        else $error("analog enables on in power down");
    a_pd_buffers_off: assert property (
        s_pd |-> !conv_set.vrbuf_n && !conv_set.vrbuf_p)
        else $error("reference buffers on in power down");
    a_slp_mod_off: assert property (s_slp |-> anlg_en == 5'h1A)
        else $error("wrong enables in sleep");
    a_rst_filter_held: assert property (s_rst |-> anlg_en == 5'h1F)
        else $error("filter not held in reset mode");
    a_run_filter_free: assert property (s_run |-> anlg_en == 5'h1E)
        else $error("wrong enables in run mode");
    a_mode_one_hot: assert property ($onehot(conv_mode))
        else $error("mode not one-hot");
    a_done_has_cause: assert property ($rose(conv_done) |->
        $past(sample_valid) && $past(conv_mode) == SDR_MODE_RUN)
        else $error("done raised without a taken sample");
    a_done_sticky: assert property ((conv_done and s_take) |=> conv_done)
        else $error("done lost on new sample");
    a_done_host_clear: assert property ($fell(conv_done) |-> !scl_in)
        else $error("done cleared outside a bus write");
    a_idle_no_done: assert property (
        !conv_done && sample_valid && conv_mode != SDR_MODE_RUN
        |=> !conv_done)
        else $error("sample taken outside run mode");
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_sda_quiet_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data changed while clock high");
endmodule : sdr_adc_ctrl_sva
bind sdr_adc_ctrl sdr_adc_ctrl_sva #(.RAW_W(RAW_W)) sdr_adc_ctrl_sva_i (
    .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .sample_in(sample_in),
    .sample_valid(sample_valid), .anlg_en(anlg_en), .conv_set(conv_set),
    .conv_mode(conv_mode), .conv_done(conv_done), .dac_value(dac_value));
`default_nettype wire

// ---- testbench/sdr_i2c_host.sv ----
// Purpose: Host model, I2C bus master of the block.
// Assumes: Open-drain data line; bench resolves the wire.
// Notes:   Eight core_clk cycles per clock high half period, nine per low half.
`timescale 1ns/100ps
`default_nettype none
module sdr_i2c_host (
    // Clock
    input wire logic core_clk,
    // Bus
    output logic scl,
    output logic m_oe,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        m_oe = 1'b0;
    end
    task automatic hp();
        repeat (8) @(posedge core_clk);
    endtask : hp
    task automatic bit_io(input logic b, output logic r);
        @(posedge core_clk);
        m_oe <= !b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda;
        scl <= 1'b0;
    endtask : bit_io
    task automatic start();
        m_oe <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        m_oe <= 1'b1;
        hp();
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        @(posedge core_clk);
        m_oe <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        m_oe <= 1'b0;
        hp();
    endtask : stop
    // Byte out, ninth bit b; ack high when the line was low
    task automatic xfer(input logic [7:0] tx, input logic b,
                        output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(b, r);
        ack = !r;
    endtask : xfer
    task automatic probe(input logic [7:0] a, output logic ok);
        logic [7:0] rx;
        start();
        xfer(a, 1'b1, rx, ok);
        stop();
    endtask : probe
    task automatic wr(input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2;
        start();
        xfer(8'hD0, 1'b1, rx, a0);
        xfer(p, 1'b1, rx, a1);
        xfer(d, 1'b1, rx, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask : wr
    task automatic rd(input logic [7:0] p, input int n,
                      output logic [23:0] v, output logic ok);
        logic [7:0] rx;
        logic a0, a1, a2, r;
        v = '0;
        start();
        xfer(8'hD0, 1'b1, rx, a0);
        xfer(p, 1'b1, rx, a1);
        start();
        xfer(8'hD1, 1'b1, rx, a2);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, i == n - 1, rx, r);
            v[8*i +: 8] = rx;
        end
        stop();
        ok = a0 & a1 & a2;
    endtask : rd
endmodule : sdr_i2c_host
`default_nettype wire

// ---- testbench/sdr_adc_ctrl_tb.sv ----
// Purpose: Self-checking bench for the result/control block.
// Assumes: Host model drives the bus; bench drives samples.
// Notes:   Reset held ten cycles; watchdog cuts a hang.
`timescale 1ns/100ps
`default_nettype none
`include "sdr_cfg.svh"
module sdr_adc_ctrl_tb;
    import sdr_pkg::*;
    localparam int RAW_W = 28;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic scl, m_oe, sda, sda_out, sda_oe, conv_done, ok;
    logic sample_valid = 1'b0;
    logic [RAW_W-1:0] sample_in = '0;
    sdr_anlg_t anlg_en;
    sdr_conv_set_t conv_set;
    sdr_mode_t conv_mode;
    logic [15:0] dac_value;
    logic [23:0] v;
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] c0 [4] = '{8'hC1, 8'h41, 8'h21, 8'h01};
    sdr_mode_t md [4] = '{SDR_MODE_PD, SDR_MODE_SLP, SDR_MODE_RST,
        SDR_MODE_RUN};
    logic [4:0] an [4] = '{5'h00, 5'h1A, 5'h1F, 5'h1E};
    logic [RAW_W-1:0] smp [6] = '{28'h0123456, 28'hFFFFFFF,
        28'h0800000, 28'hF7FFFFF, 28'h07FFFFF, 28'hF800000};
    always #4 core_clk = ~core_clk;
    // Pull-up on the data line
    assign sda = !(m_oe || sda_oe);
    sdr_adc_ctrl #(.RAW_W(RAW_W)) sdr_adc_ctrl_i (
        .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .sample_in(sample_in),
        .sample_valid(sample_valid), .anlg_en(anlg_en),
        .conv_set(conv_set), .conv_mode(conv_mode),
        .conv_done(conv_done), .dac_value(dac_value));
    sdr_i2c_host sdr_i2c_host_i (.core_clk(core_clk), .scl(scl),
        .m_oe(m_oe), .sda(sda));
    task automatic cmp(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        sdr_i2c_host_i.wr(p, d, ok);
        cmp("write ack", 24'h1, {23'h0, ok});
    endtask : wr
    task automatic rd(input logic [7:0] p, input int n,
                      input logic [23:0] e, input string nm);
        sdr_i2c_host_i.rd(p, n, v, ok);
        cmp("read ack", 24'h1, {23'h0, ok});
        cmp(nm, e, v);
    endtask : rd
    task automatic put(input logic [RAW_W-1:0] s);
        @(posedge core_clk);
        sample_in <= s;
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : put
    function automatic logic [23:0] sat(input logic signed [RAW_W-1:0] s);
        if (s > $signed(28'h07FFFFF))
            return 24'h7FFFFF;
        if (s < $signed(28'hF800000))
            return 24'h800000;
        return s[23:0];
    endfunction : sat
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        cmp("mode", {20'h0, SDR_MODE_PD}, {20'h0, conv_mode});
        cmp("analog", 24'h0, {19'h0, anlg_en});
        put(28'h0000100);
        cmp("pd done", 24'h0, {23'h0, conv_done});
        rd(`SDR_OFS_CTRL0, 1, 24'hE0, "ctrl0");
        rd(8'h0B, 1, 24'h0, "unmapped");
        sdr_i2c_host_i.probe(8'hD2, ok);
        cmp("foreign ack", 24'h0, {23'h0, ok});
        wr(`SDR_OFS_CLKSEL, 8'h1F);
        wr(`SDR_OFS_CTRL0, 8'hF1);
        wr(`SDR_OFS_CTRL1, 8'h58);
        cmp("settings", {9'h0, 4'h1, 3'h2, 5'h1F, 3'h4},
            {9'h0, conv_set});
        for (int i = 0; i < 4; i++) begin
            wr(`SDR_OFS_CTRL0, c0[i]);
            cmp("mode", {20'h0, md[i]}, {20'h0, conv_mode});
            cmp("analog", {19'h0, an[i]}, {19'h0, anlg_en});
        end
        cmp("run settings", {9'h0, 4'h1, 3'h2, 5'h1F, 3'h3},
            {9'h0, conv_set});
        for (int i = 0; i < 6; i++) begin
            put(smp[i]);
            cmp("done", 24'h1, {23'h0, conv_done});
            rd(`SDR_OFS_RES_LO, 3, sat(smp[i]), "result");
            wr(`SDR_OFS_CTRL1, 8'h00);
            cmp("done clear", 24'h0, {23'h0, conv_done});
        end
        wr(`SDR_OFS_RES_HI, 8'h55);
        wr(`SDR_OFS_CTRL1, 8'h04);
        put(28'h0000011);
        cmp("held done", 24'h0, {23'h0, conv_done});
        rd(`SDR_OFS_RES_LO, 3, 24'h800000, "held");
        wr(`SDR_OFS_CTRL1, 8'h00);
        put(28'h0000011);
        put(28'h0000022);
        cmp("done kept", 24'h1, {23'h0, conv_done});
        rd(`SDR_OFS_RES_LO, 3, 24'h000022, "released");
        wr(`SDR_OFS_DAC_LO, 8'h5A);
        cmp("dac shadow", 24'h0, {8'h0, dac_value});
        wr(`SDR_OFS_DAC_HI, 8'hC3);
        cmp("dac", 24'hC35A, {8'h0, dac_value});
        wr(`SDR_OFS_DAC_LO, 8'h11);
        rd(`SDR_OFS_DAC_LO, 1, 24'h5A, "dac low");
        cmp("dac kept", 24'hC35A, {8'h0, dac_value});
        complete_run();
    end
endmodule : sdr_adc_ctrl_tb
`default_nettype wire
